// file: dbg_cmd_pkg.sv
// shared constants and types of the debug memory command unit
package dbg_cmd_pkg;
    localparam logic [7:0] OP_PM_RD = 8'h0B;
    localparam logic [7:0] OP_DM_WR = 8'h0C;
    localparam logic [7:0] OP_DM_RD = 8'h0D;
    localparam logic [7:0] OP_CRC = 8'h0E;
    localparam logic [7:0] OP_STEP = 8'h10;
    localparam logic [7:0] BLANK_BYTE = 8'hFF;
    localparam logic [15:0] BLANK_CRC = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [16:0] FULL_SIZE = 17'h1_0000;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_AH = 4'b0001,
        S_AL = 4'b0010,
        S_SH = 4'b0011,
        S_SL = 4'b0100,
        S_WR = 4'b0101,
        S_RD = 4'b0110,
        S_CRC = 4'b0111,
        S_CHI = 4'b1000,
        S_CLO = 4'b1001
    } state_t;
endpackage

// file: debug_memory_command_unit.sv
// command handler of the on-chip debug unit for memory, crc and step commands
`timescale 1ns/100ps
module debug_memory_command_unit #(
    parameter int PMEM_BYTES = 512
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic debug_mode,
    input wire logic read_protect,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic pm_rd,
    output logic [15:0] mem_addr,
    input wire logic [7:0] pm_rdata,
    output logic dm_rd,
    input wire logic [7:0] dm_rdata,
    output logic dm_we,
    output logic [7:0] dm_wdata,
    output logic cpu_step,
    output logic busy
);
    typedef struct packed {
        dbg_cmd_pkg::state_t st;
        logic [7:0] op;
        logic [15:0] addr;
        logic [16:0] cnt;
        logic [15:0] crc;
        logic rd_pend;
        logic [1:0][7:0] bq;
        logic [1:0] bn;
        logic pm_rd;
        logic dm_rd;
        logic dm_we;
        logic [15:0] maddr;
        logic [7:0] wdata;
        logic step;
    } unit_t;

    localparam logic [16:0] PM_CNT = 17'(PMEM_BYTES);

    unit_t q;
    unit_t d;
    logic open_ok;
    logic pop;
    logic push;
    logic [7:0] pdat;
    logic quiet;

    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ b[i]) begin
                r = {r[14:0], 1'b0} ^ dbg_cmd_pkg::CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    assign open_ok = debug_mode && !read_protect;

    always_comb begin
        d = q;
        d.pm_rd = 1'b0;
        d.dm_rd = 1'b0;
        d.dm_we = 1'b0;
        d.step = 1'b0;
        d.rd_pend = q.pm_rd || q.dm_rd;
        quiet = !q.pm_rd && !q.dm_rd && !q.rd_pend;
        push = 1'b0;
        pdat = dbg_cmd_pkg::BLANK_BYTE;
        // returned memory byte goes back to the host
        if (q.rd_pend && q.st == dbg_cmd_pkg::S_RD) begin
            push = 1'b1;
            pdat = (q.op == dbg_cmd_pkg::OP_PM_RD) ? pm_rdata : dm_rdata;
        end
        if (q.rd_pend && q.st == dbg_cmd_pkg::S_CRC) begin
            d.crc = crc_upd(q.crc, pm_rdata);
        end
        case (q.st)
            dbg_cmd_pkg::S_IDLE: begin
                if (rx_valid) begin
                    d.op = rx_data;
                    if (rx_data == dbg_cmd_pkg::OP_PM_RD || rx_data == dbg_cmd_pkg::OP_DM_WR ||
                        rx_data == dbg_cmd_pkg::OP_DM_RD) begin
                        d.st = dbg_cmd_pkg::S_AH;
                    end else if (rx_data == dbg_cmd_pkg::OP_CRC) begin
                        d.addr = 16'h0000;
                        d.cnt = PM_CNT;
                        d.crc = debug_mode ? dbg_cmd_pkg::CRC_INIT : dbg_cmd_pkg::BLANK_CRC;
                        d.st = debug_mode ? dbg_cmd_pkg::S_CRC : dbg_cmd_pkg::S_CHI;
                    end else if (rx_data == dbg_cmd_pkg::OP_STEP) begin
                        d.step = open_ok;
                    end
                end
            end
            dbg_cmd_pkg::S_AH: begin
                if (rx_valid) begin
                    d.addr[15:8] = rx_data;
                    d.st = dbg_cmd_pkg::S_AL;
                end
            end
            dbg_cmd_pkg::S_AL: begin
                if (rx_valid) begin
                    d.addr[7:0] = rx_data;
                    d.st = dbg_cmd_pkg::S_SH;
                end
            end
            dbg_cmd_pkg::S_SH: begin
                if (rx_valid) begin
                    d.cnt = {9'h000, rx_data};
                    d.st = dbg_cmd_pkg::S_SL;
                end
            end
            dbg_cmd_pkg::S_SL: begin
                if (rx_valid) begin
                    // size zero stands for the full 64k transfer
                    if (q.cnt[7:0] == 8'h00 && rx_data == 8'h00) begin
                        d.cnt = dbg_cmd_pkg::FULL_SIZE;
                    end else begin
                        d.cnt = {1'b0, q.cnt[7:0], rx_data};
                    end
                    d.st = (q.op == dbg_cmd_pkg::OP_DM_WR) ? dbg_cmd_pkg::S_WR : dbg_cmd_pkg::S_RD;
                end
            end
            dbg_cmd_pkg::S_WR: begin
                if (rx_valid) begin
                    d.dm_we = open_ok;
                    d.maddr = q.addr;
                    d.wdata = rx_data;
                    d.addr = q.addr + 16'h0001;
                    d.cnt = q.cnt - 17'h0_0001;
                    if (q.cnt == 17'h0_0001) begin
                        d.st = dbg_cmd_pkg::S_IDLE;
                    end
                end
            end
            dbg_cmd_pkg::S_RD: begin
                if (q.cnt == 17'h0_0000) begin
                    if (quiet) begin
                        d.st = dbg_cmd_pkg::S_IDLE;
                    end
                end else if (quiet && q.bn < dbg_cmd_pkg::BUF_DEPTH) begin
                    d.cnt = q.cnt - 17'h0_0001;
                    d.maddr = q.addr;
                    d.addr = q.addr + 16'h0001;
                    if (q.op == dbg_cmd_pkg::OP_PM_RD) begin
                        d.pm_rd = open_ok;
                        push = !open_ok;
                    end else begin
                        d.dm_rd = debug_mode;
                        push = !debug_mode;
                    end
                end
            end
            dbg_cmd_pkg::S_CRC: begin
                // one program byte fetched per clock while scanning
                if (q.cnt != 17'h0_0000) begin
                    d.pm_rd = 1'b1;
                    d.maddr = q.addr;
                    d.addr = q.addr + 16'h0001;
                    d.cnt = q.cnt - 17'h0_0001;
                end else if (quiet) begin
                    d.st = dbg_cmd_pkg::S_CHI;
                end
            end
            dbg_cmd_pkg::S_CHI: begin
                if (q.bn < dbg_cmd_pkg::BUF_DEPTH) begin
                    push = 1'b1;
                    pdat = q.crc[15:8];
                    d.st = dbg_cmd_pkg::S_CLO;
                end
            end
            dbg_cmd_pkg::S_CLO: begin
                if (q.bn < dbg_cmd_pkg::BUF_DEPTH) begin
                    push = 1'b1;
                    pdat = q.crc[7:0];
                    d.st = dbg_cmd_pkg::S_IDLE;
                end
            end
            default: begin
                d.st = dbg_cmd_pkg::S_IDLE;
            end
        endcase
        // two-entry return buffer toward the serial side
        pop = (q.bn != 2'h0) && tx_ready;
        if (pop) begin
            d.bq[0] = q.bq[1];
            d.bn = q.bn - 2'h1;
        end
        if (push) begin
            d.bq[d.bn[0]] = pdat;
            d.bn = d.bn + 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: dbg_cmd_pkg::S_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign tx_valid = q.bn != 2'h0;
    assign tx_data = q.bq[0];
    assign pm_rd = q.pm_rd;
    assign dm_rd = q.dm_rd;
    assign dm_we = q.dm_we;
    assign mem_addr = q.maddr;
    assign dm_wdata = q.wdata;
    assign cpu_step = q.step;
    assign busy = q.st != dbg_cmd_pkg::S_IDLE;

    // checks
    a_step_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_step |-> $past(open_ok) && $past(rx_valid) && $past(rx_data) == dbg_cmd_pkg::OP_STEP)
        else $error("step issued while gated");
    a_step_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_step && !(rx_valid && rx_data == dbg_cmd_pkg::OP_STEP)) |=> !cpu_step)
        else $error("step longer than one cycle");
    a_rd_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((pm_rd || dm_rd) && q.st == dbg_cmd_pkg::S_RD) |=> !pm_rd && !dm_rd)
        else $error("two memory reads in flight");
    a_buf_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        q.bn <= dbg_cmd_pkg::BUF_DEPTH)
        else $error("return buffer overflow");
    a_cnt_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        q.cnt <= dbg_cmd_pkg::FULL_SIZE)
        else $error("byte count above 65536");
    a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !busy |-> !pm_rd && !dm_rd)
        else $error("memory read strobe while idle");
    a_wr_addr_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dm_we |-> q.addr == mem_addr + 16'h0001)
        else $error("write address did not advance");
    a_pm_blank: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.st == dbg_cmd_pkg::S_RD && q.op == dbg_cmd_pkg::OP_PM_RD && q.cnt != 17'h0_0000
        && quiet && q.bn < dbg_cmd_pkg::BUF_DEPTH && !open_ok)
        |=> !pm_rd && tx_valid && ($past(tx_valid) || tx_data == dbg_cmd_pkg::BLANK_BYTE))
        else $error("gated program read not blanked");
    a_dm_blank: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.st == dbg_cmd_pkg::S_RD && q.op == dbg_cmd_pkg::OP_DM_RD && q.cnt != 17'h0_0000
        && quiet && q.bn < dbg_cmd_pkg::BUF_DEPTH && !debug_mode)
        |=> !dm_rd && tx_valid && ($past(tx_valid) || tx_data == dbg_cmd_pkg::BLANK_BYTE))
        else $error("gated data read not blanked");
    a_write_discard: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dm_we |-> $past(open_ok) && $past(rx_valid))
        else $error("data write while gated");
    a_write_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.st == dbg_cmd_pkg::S_WR && rx_valid && open_ok) |=> dm_we && dm_wdata == $past(rx_data))
        else $error("payload byte not written");
    a_size_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.st == dbg_cmd_pkg::S_SL && rx_valid && rx_data == 8'h00 && q.cnt[7:0] == 8'h00)
        |=> q.cnt == dbg_cmd_pkg::FULL_SIZE)
        else $error("size zero not taken as 65536");
    a_pm_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.st == dbg_cmd_pkg::S_RD && q.op == dbg_cmd_pkg::OP_PM_RD) ##1 pm_rd |-> $past(open_ok))
        else $error("program read while gated");
    a_dm_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dm_rd |-> $past(debug_mode))
        else $error("data read outside debug mode");
    a_crc_blank: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.st == dbg_cmd_pkg::S_IDLE && rx_valid && rx_data == dbg_cmd_pkg::OP_CRC && !debug_mode)
        |=> q.st == dbg_cmd_pkg::S_CHI && q.crc == dbg_cmd_pkg::BLANK_CRC)
        else $error("crc not blanked");
    a_crc_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.st == dbg_cmd_pkg::S_IDLE && rx_valid && rx_data == dbg_cmd_pkg::OP_CRC && debug_mode)
        |=> q.st == dbg_cmd_pkg::S_CRC ##[1:1000] q.st == dbg_cmd_pkg::S_CHI)
        else $error("crc scan did not finish");
    a_crc_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.st == dbg_cmd_pkg::S_CHI && q.bn < dbg_cmd_pkg::BUF_DEPTH) |=> q.st == dbg_cmd_pkg::S_CLO)
        else $error("crc bytes out of order");
    a_tx_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_data))
        else $error("return byte lost under stall");
    c_step: cover property (@(posedge sys_clk) disable iff (!rst_n) cpu_step);
    c_write: cover property (@(posedge sys_clk) disable iff (!rst_n) dm_we ##1 dm_we);
    c_read_full: cover property (@(posedge sys_clk) disable iff (!rst_n)
        tx_valid && !tx_ready && q.bn == 2'h2);
    c_crc_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
        q.st == dbg_cmd_pkg::S_CLO ##1 q.st == dbg_cmd_pkg::S_IDLE);
    c_gated_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
        q.st == dbg_cmd_pkg::S_RD && !open_ok && tx_valid);
endmodule

// file: host_link_model.sv
// host debugger model: sends command bytes and takes return bytes
`timescale 1ns/100ps
module host_link_model (
    input wire logic sys_clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'hA5;
        tx_ready = 1'b0;
    end
    // one rx_valid cycle per byte, then line shows inverse value
    task automatic send(input logic [7:0] b);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
    endtask
    // opcode, address and size high byte first
    task automatic cmd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] s);
        send(op);
        send(a[15:8]);
        send(a[7:0]);
        send(s[15:8]);
        send(s[7:0]);
    endtask
    // waits for the answer under a bound, optional stall first
    task automatic recv(output logic [7:0] b, input int stall);
        int n;
        n = 0;
        b = 8'hxx;
        repeat (stall + 1) @(posedge sys_clk);
        tx_ready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!(tx_valid === 1'b1) && n < 3000);
        if (tx_valid === 1'b1) b = tx_data;
        tx_ready <= 1'b0;
    endtask
endmodule

// file: debug_memory_command_unit_bench.sv
// testbench of the debug memory command unit
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module debug_memory_command_unit_bench;
    localparam int PMB = 64;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic debug_mode = 1'b0;
    logic read_protect = 1'b0;
    logic rx_valid, tx_valid, tx_ready, pm_rd, dm_rd, dm_we, cpu_step, busy;
    logic [7:0] rx_data, tx_data, pm_rdata, dm_rdata, dm_wdata, b;
    logic [15:0] mem_addr, last_wa;
    logic [7:0] dmem [256];
    int err_count = 0;
    int cmp_count = 0;
    int we_cnt = 0;
    int step_cnt = 0;
    int k;
    always #5 sys_clk = ~sys_clk;
    host_link_model host (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    debug_memory_command_unit #(.PMEM_BYTES(PMB)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .debug_mode(debug_mode), .read_protect(read_protect), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .pm_rd(pm_rd), .mem_addr(mem_addr), .pm_rdata(pm_rdata), .dm_rd(dm_rd),
        .dm_rdata(dm_rdata), .dm_we(dm_we), .dm_wdata(dm_wdata), .cpu_step(cpu_step),
        .busy(busy));
    function automatic logic [7:0] pm_byte(logic [15:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    function automatic logic [15:0] crc_all();
        logic [15:0] c;
        logic [7:0] d;
        c = 16'hFFFF;
        for (int i = 0; i < PMB; i++) begin
            d = pm_byte(i[15:0]);
            for (int j = 7; j >= 0; j--) begin
                c = (c[15] ^ d[j]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction
    // memories answer one cycle after the strobe, else show changing junk
    initial begin
        pm_rdata = 8'h00;
        dm_rdata = 8'h00;
    end
    always @(posedge sys_clk) begin
        pm_rdata <= (pm_rd === 1'b1) ? pm_byte(mem_addr) : ~pm_rdata;
        dm_rdata <= (dm_rd === 1'b1) ? dmem[mem_addr[7:0]] : ~dm_rdata;
        if (dm_we === 1'b1) begin
            dmem[mem_addr[7:0]] <= dm_wdata;
            last_wa <= mem_addr;
            we_cnt <= we_cnt + 1;
        end
        if (cpu_step === 1'b1) step_cnt <= step_cnt + 1;
    end
    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic set_mode(input logic dbg, input logic prot);
        @(posedge sys_clk);
        debug_mode <= dbg;
        read_protect <= prot;
    endtask
    task automatic t_write_read();
        set_mode(1'b1, 1'b0);
        host.cmd(dbg_cmd_pkg::OP_DM_WR, 16'hFFFF, 16'h0002);
        host.send(8'hA1);
        host.send(8'hB2);
        repeat (3) @(posedge sys_clk);
        `CHK("wr_cnt", 2, we_cnt)
        `CHK("wrap_addr", 16'h0000, last_wa)
        host.cmd(dbg_cmd_pkg::OP_DM_RD, 16'hFFFF, 16'h0002);
        host.recv(b, 6);
        `CHK("rd0", 8'hA1, b)
        host.recv(b, 9);
        `CHK("rd1", 8'hB2, b)
    endtask
    task automatic t_gated_dm();
        set_mode(1'b0, 1'b0);
        host.cmd(dbg_cmd_pkg::OP_DM_WR, 16'h0000, 16'h0001);
        host.send(8'h11);
        set_mode(1'b1, 1'b1);
        host.cmd(dbg_cmd_pkg::OP_DM_WR, 16'h0000, 16'h0001);
        host.send(8'h22);
        repeat (3) @(posedge sys_clk);
        `CHK("gated_wr", 2, we_cnt)
        host.cmd(dbg_cmd_pkg::OP_DM_RD, 16'h0000, 16'h0001);
        host.recv(b, 0);
        `CHK("prot_rd", 8'hB2, b)
        set_mode(1'b0, 1'b0);
        host.cmd(dbg_cmd_pkg::OP_DM_RD, 16'h0000, 16'h0001);
        host.recv(b, 0);
        `CHK("nodbg_rd", dbg_cmd_pkg::BLANK_BYTE, b)
    endtask
    task automatic t_pm_read();
        set_mode(1'b1, 1'b0);
        host.cmd(dbg_cmd_pkg::OP_PM_RD, 16'h0005, 16'h0003);
        for (k = 0; k < 3; k++) begin
            host.recv(b, k * 4);
            `CHK("pm_rd", pm_byte(16'h0005 + k[15:0]), b)
        end
        set_mode(1'b1, 1'b1);
        host.cmd(dbg_cmd_pkg::OP_PM_RD, 16'h0005, 16'h0001);
        host.recv(b, 0);
        `CHK("pm_prot", dbg_cmd_pkg::BLANK_BYTE, b)
        set_mode(1'b0, 1'b0);
        host.cmd(dbg_cmd_pkg::OP_PM_RD, 16'h0005, 16'h0001);
        host.recv(b, 0);
        `CHK("pm_nodbg", dbg_cmd_pkg::BLANK_BYTE, b)
    endtask
    task automatic t_crc(input logic dbg, input logic [15:0] ex);
        set_mode(dbg, 1'b0);
        host.send(dbg_cmd_pkg::OP_CRC);
        host.recv(b, 0);
        `CHK("crc_hi", ex[15:8], b)
        host.recv(b, 3);
        `CHK("crc_lo", ex[7:0], b)
    endtask
    task automatic t_step();
        for (k = 0; k < 3; k++) begin
            set_mode(k != 2, k == 1);
            host.send(dbg_cmd_pkg::OP_STEP);
            repeat (3) @(posedge sys_clk);
            `CHK("step_cnt", 1, step_cnt)
        end
    endtask
    task automatic t_size_zero(input logic [7:0] op);
        set_mode(1'b1, 1'b0);
        host.cmd(op, 16'h0000, 16'h0000);
        if (op == dbg_cmd_pkg::OP_DM_WR) begin
            for (k = 0; k < 300; k++) host.send(k[7:0]);
            repeat (3) @(posedge sys_clk);
            `CHK("full_wr_cnt", 302, we_cnt)
        end else begin
            for (k = 0; k < 4; k++) begin
                host.recv(b, 0);
                `CHK("full_rd", k[7:0], b)
            end
        end
        `CHK("full_size_busy", 1'b1, busy)
        do_reset();
        `CHK("busy_after_rst", 1'b0, busy)
    endtask
    task automatic finish_test();
        $display("err_count %0d cmp_count %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_write_read();
        t_gated_dm();
        t_pm_read();
        t_crc(1'b1, crc_all());
        t_crc(1'b0, dbg_cmd_pkg::BLANK_CRC);
        t_step();
        t_size_zero(dbg_cmd_pkg::OP_DM_WR);
        t_size_zero(dbg_cmd_pkg::OP_DM_RD);
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_count++;
        finish_test();
    end
endmodule
